// ### bench/mrba_sta_model.sv
// station management model that issues register accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module mrba_sta_model (
	// clock
	input wire logic i_clk,
	// request to the bank
	output var mrba_pkg::mrba_req_t o_req
);
	// ****************************************
	// access driver
	// ****************************************
	initial o_req = '0;
	// caller sits just after an edge; request holds through the sampling edge
	task automatic acc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
		o_req = '{wr: w, rd: r, addr: a, data: d};
		@(posedge i_clk);
		#2;
	endtask : acc
	// released data is inverted so a stale word never looks valid; one edge passes so the next request starts clean
	task automatic idle();
		o_req.wr = 1'b0;
		o_req.rd = 1'b0;
		o_req.data = ~o_req.data;
		@(posedge i_clk);
		#2;
	endtask : idle
endmodule : mrba_sta_model
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the register bit access bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk;
	logic i_reset;
	logic ce;
	logic [4:0] straps;
	logic [15:0] o_rdata;
	logic o_rvalid;
	logic o_override;
	mrba_pkg::mrba_req_t req;
	logic [15:0] ex [32];
	logic [15:0] cm [32];
	logic [15:0] rw [32];
	logic [15:0] gt [32];
	logic [15:0] w0 [32];
	logic [31:0] q [$];
	logic [31:0] e;
	logic [31:0] rnd = 32'h7DEDD780;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	mrba_bank dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_strap_pins(straps), .i_req(req),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_override(o_override));
	mrba_sta_model sta_u (.i_clk(i_clk), .o_req(req));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s, input logic [15:0] m);
		num_checks++;
		if ((s & m) !== (x & m)) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, x & m, s & m);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	// straps change each reset so a stuck default shows up
	task automatic do_reset();
		rnd = nxt(rnd);
		straps = rnd[4:0];
		i_reset = 1'b1;
		repeat (2) @(posedge i_clk);
		#2;
		i_reset = 1'b0;
		foreach (ex[i]) begin
			ex[i] = (i > 19) ? 16'hFFFF : 16'h0000;
			cm[i] = 16'hFFFF;
		end
		ex[0] = 16'h3000;
		ex[16] = {11'h000, straps};
		cm[16] = 16'hFFEF;
	endtask : do_reset
	// expectation is noted before the write lands: a same-cycle read sees the old word
	task automatic acc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
		logic o;
		logic [15:0] g;
		o = ex[16][15];
		g = o ? gt[a] : 16'h0000;
		if (r) q.push_back({cm[a], ex[a]});
		if (w && a < 5'h14) begin
			ex[a] = ((ex[a] & ~(rw[a] | g)) | (d & (rw[a] | g))) & ~(w0[a] & ~d);
			cm[a] = cm[a] | (w0[a] & ~d);
			if (o) ex[16][15] = 1'b0;
		end
		sta_u.acc(w, r, a, d);
		chk("override", {15'h0000, ex[16][15]}, {15'h0000, o_override}, 16'h0001);
	endtask : acc
	task automatic read_all();
		for (int i = 0; i < 32; i++) acc(1'b0, 1'b1, i[4:0], 16'h0000);
		sta_u.idle();
	endtask : read_all
	always @(negedge i_clk) begin
		if (o_rvalid === 1'b1) begin
			if (q.size() > 0) begin
				e = q.pop_front();
				chk("rdata", e[15:0], o_rdata, e[31:16]);
			end else begin
				mismatches++;
				$display("Error rvalid expected 0 seen 1");
			end
		end
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		logic [4:0] a;
		logic [15:0] d;
		i_reset = 1'b1;
		ce = 1'b1;
		straps = 5'h00;
		foreach (rw[i]) begin
			rw[i] = 16'h0000;
			gt[i] = 16'h0000;
			w0[i] = 16'h0000;
		end
		rw[0] = 16'hFF80;
		rw[16] = 16'h8000;
		gt[16] = 16'h0F00;
		w0[16] = 16'h0010;
		rw[18] = 16'h00FF;
		w0[18] = 16'h8000;
		do_reset();
		read_all();
		$display("test defaults done");
		repeat (400) begin
			rnd = nxt(rnd);
			a = rnd[1] ? (rnd[0] ? 5'h10 : 5'h12) : rnd[8:4];
			d = rnd[31:16];
			if (a == 5'h00) d[6:0] = 7'h00;
			acc(rnd[2], rnd[3] | ~rnd[2], a, d);
		end
		sta_u.idle();
		$display("test random access done");
		// a frozen edge must drop both the write and the read; read_all then shows nothing landed
		ce = 1'b0;
		sta_u.acc(1'b1, 1'b1, 5'h12, ~ex[18]);
		ce = 1'b1;
		sta_u.idle();
		read_all();
		$display("test clock enable done");
		do_reset();
		read_all();
		repeat (3) @(posedge i_clk);
		chk("pending", 16'h0000, 16'(q.size()), 16'hFFFF);
		$display("test second reset done");
		close_out();
	end
endmodule : testbench
`default_nettype wire

// ### hdl/mrba_bank.sv
// register bank with per-bit access control and reset defaults
`timescale 1ns/1ps
`default_nettype none
module mrba_bank (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// strap pins
	input wire logic [4:0] i_strap_pins,
	// management access
	input wire mrba_pkg::mrba_req_t i_req,
	// read answer and override flag
	output logic [15:0] o_rdata,
	output logic o_rvalid,
	output logic o_override
);
	// ****************************************
	// storage
	// ****************************************
	logic [15:0] regs_ff [mrba_pkg::MRBA_NREG];
	logic [15:0] nxt_regs [mrba_pkg::MRBA_NREG];
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic rvalid_ff;
	logic nxt_rvalid;
	logic [15:0] merged;
	mrba_pkg::mrba_reg_attr_t wattr;
	logic ovr_now;
	// read source as the bank sees it at the request edge, kept for the read check
	logic [15:0] rd_src;

	assign wattr = mrba_pkg::mrba_attr(i_req.addr);
	assign ovr_now = regs_ff[mrba_pkg::MRBA_OVR_REG][mrba_pkg::MRBA_OVR_BIT];
	assign rd_src = regs_ff[i_req.addr];

	mrba_bit_merge u_merge (
		.i_attr(wattr),
		.i_old(regs_ff[i_req.addr]),
		.i_wdata(i_req.data),
		.i_ovr(ovr_now),
		.o_new(merged)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		mrba_pkg::mrba_reg_attr_t a;
		a = '0;
		for (int i = 0; i < mrba_pkg::MRBA_NREG; i++) begin
			nxt_regs[i] = regs_ff[i];
		end
		nxt_rdata = rdata_ff;
		nxt_rvalid = 1'b0;
		if (i_reset) begin
			for (int i = 0; i < mrba_pkg::MRBA_NREG; i++) begin
				a = mrba_pkg::mrba_attr(5'(i));
				// bits with no default keep whatever they held; a strap level always wins
				nxt_regs[i] = (regs_ff[i] & ~a.has_dflt & ~a.strap_mask) | (a.dflt & a.has_dflt & ~a.strap_mask)
					| ((16'(i_strap_pins) << a.strap_lsb) & a.strap_mask);
			end
			nxt_rdata = 16'h0000;
		end else begin
			if (i_req.wr && wattr.present) begin
				nxt_regs[i_req.addr] = merged;
				// any write to a present register consumes the override, including one to another register
				if (ovr_now) begin
					nxt_regs[mrba_pkg::MRBA_OVR_REG][mrba_pkg::MRBA_OVR_BIT] = 1'b0;
				end
				if (ovr_now && i_req.addr == mrba_pkg::MRBA_OVR_REG) begin
					nxt_regs[mrba_pkg::MRBA_OVR_REG][mrba_pkg::MRBA_OVR_BIT] = 1'b0;
				end
			end
			if (i_req.rd) begin
				nxt_rdata = wattr.present ? regs_ff[i_req.addr] : mrba_pkg::MRBA_UNMAPPED_RD;
				nxt_rvalid = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			for (int i = 0; i < mrba_pkg::MRBA_NREG; i++) begin
				regs_ff[i] <= nxt_regs[i];
			end
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// output of the override flag is registered so o_ stays flop-driven
	logic override_ff;
	logic nxt_override;
	assign nxt_override = i_reset ? 1'b0 : nxt_regs[mrba_pkg::MRBA_OVR_REG][mrba_pkg::MRBA_OVR_BIT];
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			override_ff <= nxt_override;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_rvalid = rvalid_ff;
	assign o_override = override_ff;

	// ****************************************
	// assertions: read-only and strap bits
	// ****************************************
	property p_ro_hold;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == 5'h01) |=> (regs_ff[1] == $past(regs_ff[1]));
	endproperty
	a_ro_hold: assert property (p_ro_hold) else $error("read-only register changed on write");
	property p_ro_strap;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == mrba_pkg::MRBA_OVR_REG)
			|=> (regs_ff[16][3:0] == $past(regs_ff[16][3:0]));
	endproperty
	a_ro_strap: assert property (p_ro_strap) else $error("strapped read-only bits changed on write");

	// ****************************************
	// assertions: override-gated bits
	// ****************************************
	// the gate is sampled before the write, so a write that sets 16.15 opens nothing yet
	property p_ovr_block;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == 5'h10 && !ovr_now)
			|=> (regs_ff[16][11:8] == $past(regs_ff[16][11:8]));
	endproperty
	a_ovr_block: assert property (p_ovr_block) else $error("gated bits changed without override");
	property p_ovr_pass;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == 5'h10 && ovr_now)
			|=> (regs_ff[16][11:8] == $past(i_req.data[11:8])) && !regs_ff[16][15];
	endproperty
	a_ovr_pass: assert property (p_ovr_pass) else $error("override write not applied or not cleared");
	// a write to an absent register never reaches the bank, so it leaves the override armed
	property p_ovr_selfclr;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && wattr.present && ovr_now)
			|=> !regs_ff[mrba_pkg::MRBA_OVR_REG][mrba_pkg::MRBA_OVR_BIT];
	endproperty
	a_ovr_selfclr: assert property (p_ovr_selfclr) else $error("override did not self-clear");

	// ****************************************
	// assertions: read/write and write-zero-only bits
	// ****************************************
	property p_rw_write;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == 5'h12) |=> (regs_ff[18][7:0] == $past(i_req.data[7:0]));
	endproperty
	a_rw_write: assert property (p_rw_write) else $error("read/write bits not stored");
	property p_w0_noset;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == 5'h12 && !regs_ff[18][15]) |=> !regs_ff[18][15];
	endproperty
	a_w0_noset: assert property (p_w0_noset) else $error("write-zero-only bit was set");
	property p_w0_clear;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == mrba_pkg::MRBA_OVR_REG && !i_req.data[4])
			|=> !regs_ff[16][4];
	endproperty
	a_w0_clear: assert property (p_w0_clear) else $error("write-zero-only bit not cleared");
	property p_w0_noset16;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.wr && i_req.addr == mrba_pkg::MRBA_OVR_REG && !regs_ff[16][4])
			|=> !regs_ff[16][4];
	endproperty
	a_w0_noset16: assert property (p_w0_noset16) else $error("strapped write-zero-only bit was set");

	// ****************************************
	// assertions: reset
	// ****************************************
	// no disable here: these watch the reset cycles themselves
	property p_reset_dflt;
		@(posedge i_clk) (i_reset && i_ce) |=> (regs_ff[0] == 16'h3000);
	endproperty
	a_reset_dflt: assert property (p_reset_dflt) else $error("default not loaded");
	property p_strap;
		@(posedge i_clk) (i_reset && i_ce) |=> (regs_ff[16][4:0] == $past(i_strap_pins));
	endproperty
	a_strap: assert property (p_strap) else $error("strap not captured");
	property p_reset_out;
		@(posedge i_clk) (i_reset && i_ce)
			|=> (!o_rvalid && (o_rdata == 16'h0000) && !o_override);
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");

	// ****************************************
	// assertions: read path and clock enable
	// ****************************************
	property p_read_data;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.rd && wattr.present)
			|=> (o_rvalid && (o_rdata == $past(rd_src)));
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data not the stored word");
	// absent registers answer all ones so a wrong address never looks like data
	property p_unmapped;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_req.rd && i_req.addr > 5'h13) |=> (o_rvalid && o_rdata == mrba_pkg::MRBA_UNMAPPED_RD);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not all ones");
	property p_rvalid_pulse;
		@(posedge i_clk) disable iff (i_reset)
		(i_ce && !i_req.rd) |=> !o_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a read");
	// a frozen edge must look like no edge at all, answer and storage alike
	property p_ce_freeze;
		@(posedge i_clk) disable iff (i_reset)
		!i_ce |=> (o_rvalid == $past(o_rvalid)) && (o_rdata == $past(o_rdata))
			&& (regs_ff[18] == $past(regs_ff[18]));
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

	// ****************************************
	// cover
	// ****************************************
	c_ovr_write: cover property (@(posedge i_clk) i_ce && i_req.wr && ovr_now);
	c_w0_clear: cover property (@(posedge i_clk) i_ce && i_req.wr && i_req.addr == 5'h10 && regs_ff[16][4] && !i_req.data[4]);
	c_read: cover property (@(posedge i_clk) i_ce && i_req.rd);
	c_unmapped: cover property (@(posedge i_clk) i_ce && i_req.rd && !wattr.present);
endmodule : mrba_bank
`default_nettype wire

// ### hdl/mrba_bit_merge.sv
// per-bit write merge of one register
`timescale 1ns/1ps
`default_nettype none
module mrba_bit_merge (
	// attributes and data
	input wire mrba_pkg::mrba_reg_attr_t i_attr,
	input wire logic [15:0] i_old,
	input wire logic [15:0] i_wdata,
	input wire logic i_ovr,
	// merged value
	output logic [15:0] o_new
);
	logic [15:0] ovr_en;
	always_comb begin
		ovr_en = i_ovr ? i_attr.ovr_mask : 16'h0000;
		o_new = (i_old & ~(i_attr.rw_mask | ovr_en | i_attr.w0_mask))
			| (i_wdata & (i_attr.rw_mask | ovr_en))
			| (i_old & i_wdata & i_attr.w0_mask);
	end
endmodule : mrba_bit_merge
`default_nettype wire

// ### hdl/mrba_pkg.sv
// package of constants and types for the management register bit access bank
// Summary of operation
// - read-only bits read back, ignore writes
// - override-gated bits readable, write gated by 16.15
// - override clear: gated bit writes discarded
// - override set: next write to a present register lands, override self-clears
// - read/write bits always readable and writable, except 16.15 written while the override is set: the self-clear wins
// - write-zero-only bits: write may only clear
// - reset loads every defined default value
// - strap pins sampled during reset as defaults
// - bits without default hold any value
// - every register is sixteen bits wide
package mrba_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int unsigned MRBA_DATA_W = 16;
	localparam int unsigned MRBA_ADDR_W = 5;
	localparam int unsigned MRBA_NREG = 32;
	localparam int unsigned MRBA_STRAP_W = 5;
	localparam logic [4:0] MRBA_OVR_REG = 5'h10;
	localparam int unsigned MRBA_OVR_BIT = 15;
	localparam logic [15:0] MRBA_UNMAPPED_RD = 16'hFFFF;
	// ****************************************
	// per-register bit type masks and defaults
	// ****************************************
	typedef struct packed {
		logic [15:0] rw_mask;
		logic [15:0] ovr_mask;
		logic [15:0] w0_mask;
		logic [15:0] strap_mask;
		logic [4:0] strap_lsb;
		logic [15:0] dflt;
		logic [15:0] has_dflt;
		logic present;
	} mrba_reg_attr_t;
	// one management access from the serial frame engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] data;
	} mrba_req_t;
	// generic attributes; real layouts are filled per register by the integrator
	function automatic mrba_reg_attr_t mrba_attr(input logic [4:0] a);
		mrba_reg_attr_t r;
		r = '0;
		r.present = (a <= 5'h13);
		r.has_dflt = 16'hFFFF;
		unique case (a)
			5'h00: begin
				r.rw_mask = 16'hFF80;
				r.dflt = 16'h3000;
			end
			5'h10: begin
				r.rw_mask = 16'h8000;
				r.ovr_mask = 16'h0F00;
				r.w0_mask = 16'h0010;
				r.strap_mask = 16'h001F;
				r.strap_lsb = 5'h00;
				r.dflt = 16'h0000;
				r.has_dflt = 16'hFFEF;
			end
			5'h12: begin
				r.rw_mask = 16'h00FF;
				r.w0_mask = 16'h8000;
				r.dflt = 16'h0000;
			end
			default: begin
				r.rw_mask = 16'h0000;
				r.dflt = 16'h0000;
			end
		endcase
		return r;
	endfunction : mrba_attr
endpackage : mrba_pkg
